// >>> hw/dmarp_pkg.sv
// Shared constants for the repeat-mode DMA channel
package dmarp_pkg;
	localparam int APB_AW = 8;
	localparam int APB_DW = 32;
	localparam int MAR_W = 24;
	localparam int IO_SIDE_ADDRESS_W = 16;
	localparam int CNT_W = 8;
	localparam int DATA_W = 16;
	// Register byte offsets
	localparam logic [APB_AW-1:0] OFF_CTRL = 8'h00;
	localparam logic [APB_AW-1:0] OFF_BAND = 8'h04;
	localparam logic [APB_AW-1:0] OFF_WEN = 8'h08;
	localparam logic [APB_AW-1:0] OFF_MAR = 8'h0C;
	localparam logic [APB_AW-1:0] OFF_IO_SIDE_ADDRESS = 8'h10;
	localparam logic [APB_AW-1:0] OFF_CNT = 8'h14;
	localparam logic [APB_AW-1:0] OFF_STAT = 8'h18;
	// Channel control fields
	localparam int CTRL_W = 5;
	localparam int CTRL_WORD = 0;
	localparam int CTRL_DEC = 1;
	localparam int CTRL_RPE = 2;
	localparam int CTRL_TRANSFER_END_IRQ_ENABLE = 3;
	localparam int CTRL_DIR = 4;
	localparam logic [CTRL_W-1:0] CTRL_RESET = 5'h00;
	// Band control fields
	localparam int BAND_W = 16;
	localparam int BAND_DTE_CH = 4;
	localparam logic [BAND_W-1:0] BAND_PROT_MASK = 16'h0111;
	localparam logic [BAND_W-1:0] BAND_AE_MASK = 16'hF000;
	localparam logic [BAND_W-1:0] BAND_ALL = 16'hFFFF;
	localparam logic [BAND_W-1:0] BAND_RESET = 16'h0000;
	// Write enable and status fields
	localparam int WEN_W = 2;
	localparam int WEN_A = 0;
	localparam int STAT_STOP = 0;
	localparam int STAT_BUSY = 1;
	localparam int CNT_HOLD_LSB = 8;
	// Fixed upper page of the I/O side address
	localparam logic [7:0] IO_SIDE_ADDRESS_PAGE = 8'hFF;
	localparam logic [CNT_W-1:0] CNT_LAST = 8'h01;
	localparam logic [MAR_W-1:0] STEP_BYTE = 24'h000001;
	localparam logic [MAR_W-1:0] STEP_WORD = 24'h000002;
endpackage : dmarp_pkg

// >>> hw/dmarp_xfer_if.sv
// Hand-off between channel sequencer and bus engine
`timescale 1ns/1ps
interface dmarp_xfer_if;
	logic start;
	logic [dmarp_pkg::MAR_W-1:0] src;
	logic [dmarp_pkg::MAR_W-1:0] dst;
	logic word;
	logic done;
	logic busy;
	modport main (output start, output src, output dst, output word, input done, input busy);
	modport eng (input start, input src, input dst, input word, output done, output busy);
endinterface : dmarp_xfer_if

// >>> hw/dmarp_engine.sv
// Bus engine: one read from source, one write to destination
`timescale 1ns/1ps
module dmarp_engine #(
	parameter int ADDR_W = dmarp_pkg::MAR_W
) (
	// Clock and reset
	input wire logic sys_clk_i,
	input wire logic rst_n_i,
	// Sequencer side
	dmarp_xfer_if.eng xf,
	// System bus master
	output logic bus_req_o,
	output logic [ADDR_W-1:0] bus_addr_o,
	output logic bus_we_o,
	output logic bus_word_o,
	output logic [dmarp_pkg::DATA_W-1:0] bus_wdata_o,
	input wire logic bus_ack_i,
	input wire logic [dmarp_pkg::DATA_W-1:0] bus_rdata_i
);
	import dmarp_pkg::*;

	typedef enum logic [1:0] {E_IDLE, E_RD, E_WR} dmarp_eng_type;
	dmarp_eng_type state_q;
	logic [ADDR_W-1:0] dst_q;
	logic done_q;

	if (ADDR_W != MAR_W) begin : g_bad_width
		$error("dmarp_engine: ADDR_W must equal the memory address width");
	end

	assign xf.busy = (state_q != E_IDLE);
	assign xf.done = done_q;

	always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			state_q <= E_IDLE;
			bus_req_o <= 1'b0;
			bus_addr_o <= '0;
			bus_we_o <= 1'b0;
			bus_word_o <= 1'b0;
			bus_wdata_o <= '0;
			dst_q <= '0;
			done_q <= 1'b0;
		end else begin
			done_q <= 1'b0;
			case (state_q)
				E_IDLE: begin
					if (xf.start) begin
						bus_addr_o <= xf.src;
						dst_q <= xf.dst;
						bus_word_o <= xf.word;
						bus_we_o <= 1'b0;
						bus_req_o <= 1'b1;
						state_q <= E_RD;
					end
				end
				E_RD: begin
					// Request stays up; address turns to the destination
					if (bus_ack_i) begin
						bus_wdata_o <= bus_rdata_i;
						bus_addr_o <= dst_q;
						bus_we_o <= 1'b1;
						state_q <= E_WR;
					end
				end
				E_WR: begin
					if (bus_ack_i) begin
						bus_req_o <= 1'b0;
						bus_we_o <= 1'b0;
						done_q <= 1'b1;
						state_q <= E_IDLE;
					end
				end
				default: state_q <= E_IDLE;
			endcase
		end
	end

	read_first_a: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
		xf.start && state_q == E_IDLE |=> bus_req_o && !bus_we_o && bus_addr_o == $past(xf.src))
		else $error("Transfer did not open with a source read");
	write_done_a: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
		state_q == E_WR && bus_ack_i |=> done_q && !bus_req_o)
		else $error("Completed write did not signal done");
endmodule : dmarp_engine

// >>> hw/dmarp_channel.sv
// Repeat-mode DMA channel: registers, write protection and transfer sequencing
`timescale 1ns/1ps
// What this block does
// - Registers are reachable from reset, and the stop bit blocks the start of every transfer while it is set.
// - While the channel write enable is 0, writes to the control register and band bits 8, 4, 0 are ignored.
// - Writes from the transfer controller port never change band bits 15 to 12.
// - A transfer controller write of 1 to the band enable bits takes effect at once while the channel write enable is 1, no prior read needed.
// - Memory address, I/O address and count registers take writes at any time.
// - Repeat mode runs when repeat enable is 1 and the transfer end interrupt enable is 0.
// - Each request moves one byte or word, then steps the memory address, for the programmed count.
// - At the end of the count in repeat mode, address and live count are restored and transfers go on.
// - Direction 0 reads memory and writes I/O, direction 1 the reverse, and the I/O address never moves.
// - The memory address steps up or down each transfer and returns to its start value at the end of the count in repeat mode only.
// - The live count drops each transfer and at the end reloads from the hold byte in repeat mode or clears to 0 otherwise; the hold byte never changes by itself.
module dmarp_channel (
	// Clock and reset
	input wire logic sys_clk_i,
	input wire logic rst_n_i,
	// APB slave
	input wire logic psel_i,
	input wire logic penable_i,
	input wire logic pwrite_i,
	input wire logic [dmarp_pkg::APB_AW-1:0] paddr_i,
	input wire logic [dmarp_pkg::APB_DW-1:0] pwdata_i,
	output logic [dmarp_pkg::APB_DW-1:0] prdata_o,
	output logic pready_o,
	output logic pslverr_o,
	// Transfer controller write port
	input wire logic dtc_valid_i,
	output logic dtc_ready_o,
	input wire logic [dmarp_pkg::APB_AW-1:0] dtc_addr_i,
	input wire logic [dmarp_pkg::APB_DW-1:0] dtc_wdata_i,
	// Transfer request
	input wire logic xfer_req_i,
	// System bus master
	output logic bus_req_o,
	output logic [dmarp_pkg::MAR_W-1:0] bus_addr_o,
	output logic bus_we_o,
	output logic bus_word_o,
	output logic [dmarp_pkg::DATA_W-1:0] bus_wdata_o,
	input wire logic bus_ack_i,
	input wire logic [dmarp_pkg::DATA_W-1:0] bus_rdata_i
);
	import dmarp_pkg::*;

	typedef enum logic {M_IDLE, M_RUN} dmarp_main_type;

	function automatic logic [BAND_W-1:0] merge_bits(input logic [BAND_W-1:0] old_v,
		input logic [BAND_W-1:0] new_v, input logic [BAND_W-1:0] mask);
		merge_bits = (old_v & ~mask) | (new_v & mask);
	endfunction : merge_bits

	function automatic logic [MAR_W-1:0] mar_step(input logic [MAR_W-1:0] memory_side_address,
		input logic word, input logic dec);
		logic [MAR_W-1:0] step;
		step = word ? STEP_WORD : STEP_BYTE;
		mar_step = dec ? memory_side_address - step : memory_side_address + step;
	endfunction : mar_step

	dmarp_main_type state_q;
	logic [CTRL_W-1:0] ctrl_q;
	logic [BAND_W-1:0] band_q;
	logic [WEN_W-1:0] wen_q;
	logic [MAR_W-1:0] mar_q;
	logic [MAR_W-1:0] mar_start_q;
	logic [IO_SIDE_ADDRESS_W-1:0] io_side_address_q;
	logic [CNT_W-1:0] hold_q;
	logic [CNT_W-1:0] live_q;
	logic stop_q;
	logic req_pend_q;
	logic [APB_DW-1:0] rdata_q;
	logic err_q;
	logic apb_wr;
	logic dtc_wr;
	logic wr_en;
	logic [APB_AW-1:0] wr_addr;
	logic [APB_DW-1:0] wr_data;
	logic [BAND_W-1:0] band_mask;
	logic repeat_mode;
	logic last;
	logic upd;
	logic hw_end;
	logic go;
	logic [MAR_W-1:0] io_full;

	dmarp_xfer_if x ();

	dmarp_engine #(
		.ADDR_W(MAR_W)
	) u_engine (
		.sys_clk_i(sys_clk_i),
		.rst_n_i(rst_n_i),
		.xf(x.eng),
		.bus_req_o(bus_req_o),
		.bus_addr_o(bus_addr_o),
		.bus_we_o(bus_we_o),
		.bus_word_o(bus_word_o),
		.bus_wdata_o(bus_wdata_o),
		.bus_ack_i(bus_ack_i),
		.bus_rdata_i(bus_rdata_i)
	);

	// APB write access phase owns the write path; the controller port waits a cycle
	assign apb_wr = psel_i & penable_i & pwrite_i;
	assign dtc_ready_o = ~apb_wr;
	assign dtc_wr = dtc_valid_i & ~apb_wr;
	assign wr_en = apb_wr | dtc_wr;
	assign wr_addr = apb_wr ? paddr_i : dtc_addr_i;
	assign wr_data = apb_wr ? pwdata_i : dtc_wdata_i;
	assign pready_o = 1'b1;
	assign prdata_o = rdata_q;
	assign pslverr_o = psel_i & penable_i & err_q;

	assign repeat_mode = ctrl_q[CTRL_RPE] & ~ctrl_q[CTRL_TRANSFER_END_IRQ_ENABLE];
	assign last = (live_q == CNT_LAST);
	assign upd = x.done;
	assign hw_end = upd & last & ~repeat_mode;
	assign go = req_pend_q & band_q[BAND_DTE_CH] & ~stop_q & ~x.busy;
	assign io_full = {IO_SIDE_ADDRESS_PAGE, io_side_address_q};

	always_comb begin
		band_mask = BAND_ALL;
		if (!wen_q[WEN_A]) begin
			band_mask = band_mask & ~BAND_PROT_MASK;
		end
		if (dtc_wr) begin
			band_mask = band_mask & ~BAND_AE_MASK;
		end
	end

	// Channel control
	always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			ctrl_q <= CTRL_RESET;
		end else if (wr_en && wr_addr == OFF_CTRL && wen_q[WEN_A]) begin
			ctrl_q <= wr_data[CTRL_W-1:0];
		end
	end

	// Band control; a write in the same cycle beats the end-of-count clear
	always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			band_q <= BAND_RESET;
		end else if (wr_en && wr_addr == OFF_BAND) begin
			band_q <= merge_bits(band_q, wr_data[BAND_W-1:0], band_mask);
		end else if (hw_end) begin
			band_q[BAND_DTE_CH] <= 1'b0;
		end
	end

	// Write enables
	always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			wen_q <= '0;
		end else if (wr_en && wr_addr == OFF_WEN) begin
			wen_q <= wr_data[WEN_W-1:0];
		end
	end

	// Memory address with its saved start value
	always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			mar_q <= '0;
			mar_start_q <= '0;
		end else if (wr_en && wr_addr == OFF_MAR) begin
			mar_q <= wr_data[MAR_W-1:0];
			mar_start_q <= wr_data[MAR_W-1:0];
		end else if (upd) begin
			if (last && repeat_mode) begin
				mar_q <= mar_start_q;
			end else begin
				mar_q <= mar_step(mar_q, ctrl_q[CTRL_WORD], ctrl_q[CTRL_DEC]);
			end
		end
	end

	// I/O address: only software moves it
	always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			io_side_address_q <= '0;
		end else if (wr_en && wr_addr == OFF_IO_SIDE_ADDRESS) begin
			io_side_address_q <= wr_data[IO_SIDE_ADDRESS_W-1:0];
		end
	end

	// Transfer count; hold byte changes only by a write
	always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			hold_q <= '0;
			live_q <= '0;
		end else if (wr_en && wr_addr == OFF_CNT) begin
			hold_q <= wr_data[CNT_HOLD_LSB+CNT_W-1:CNT_HOLD_LSB];
			live_q <= wr_data[CNT_W-1:0];
		end else if (upd) begin
			if (last) begin
				live_q <= repeat_mode ? hold_q : '0;
			end else begin
				live_q <= live_q - CNT_LAST;
			end
		end
	end

	// Module stop
	always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			stop_q <= 1'b0;
		end else if (wr_en && wr_addr == OFF_STAT) begin
			stop_q <= wr_data[STAT_STOP];
		end
	end

	// Pending request; a new request wins over the clear at start
	always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			req_pend_q <= 1'b0;
		end else if (xfer_req_i) begin
			req_pend_q <= 1'b1;
		end else if (x.start) begin
			req_pend_q <= 1'b0;
		end
	end

	// Sequencer
	always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			state_q <= M_IDLE;
			x.start <= 1'b0;
			x.src <= '0;
			x.dst <= '0;
			x.word <= 1'b0;
		end else begin
			x.start <= 1'b0;
			case (state_q)
				M_IDLE: begin
					if (go) begin
						x.start <= 1'b1;
						x.src <= ctrl_q[CTRL_DIR] ? io_full : mar_q;
						x.dst <= ctrl_q[CTRL_DIR] ? mar_q : io_full;
						x.word <= ctrl_q[CTRL_WORD];
						state_q <= M_RUN;
					end
				end
				M_RUN: begin
					// Stop is sampled only between transfers so a bus cycle is never cut
					if (x.done) begin
						state_q <= M_IDLE;
					end
				end
				default: state_q <= M_IDLE;
			endcase
		end
	end

	// Read data and error are prepared in the setup phase so pready can stay high
	always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			rdata_q <= '0;
			err_q <= 1'b0;
		end else if (psel_i && !penable_i) begin
			err_q <= 1'b0;
			rdata_q <= '0;
			case (paddr_i)
				OFF_CTRL: rdata_q[CTRL_W-1:0] <= ctrl_q;
				OFF_BAND: rdata_q[BAND_W-1:0] <= band_q;
				OFF_WEN: rdata_q[WEN_W-1:0] <= wen_q;
				OFF_MAR: rdata_q[MAR_W-1:0] <= mar_q;
				OFF_IO_SIDE_ADDRESS: rdata_q[IO_SIDE_ADDRESS_W-1:0] <= io_side_address_q;
				OFF_CNT: rdata_q[2*CNT_W-1:0] <= {hold_q, live_q};
				OFF_STAT: begin
					rdata_q[STAT_STOP] <= stop_q;
					rdata_q[STAT_BUSY] <= (state_q != M_IDLE);
				end
				default: err_q <= 1'b1;
			endcase
		end
	end

	default clocking cb @(posedge sys_clk_i);
	endclocking
	default disable iff (!rst_n_i);

	// Protection and controller port
	stop_halts_a: assert property (stop_q |=> !x.start)
		else $error("Transfer started while stopped");
	ctrl_protect_a: assert property (wr_en && wr_addr == OFF_CTRL && !wen_q[WEN_A] |=> $stable(ctrl_q))
		else $error("Protected control register changed");
	band_protect_a: assert property (wr_en && wr_addr == OFF_BAND && !wen_q[WEN_A] && !hw_end
		|=> (band_q & BAND_PROT_MASK) == ($past(band_q) & BAND_PROT_MASK))
		else $error("Protected band bits changed");
	dtc_addr_en_a: assert property (dtc_wr && dtc_addr_i == OFF_BAND
		|=> (band_q & BAND_AE_MASK) == ($past(band_q) & BAND_AE_MASK))
		else $error("Controller port altered address enable bits");
	dtc_set_a: assert property (dtc_wr && dtc_addr_i == OFF_BAND && wen_q[WEN_A]
		&& dtc_wdata_i[BAND_DTE_CH]
		|=> band_q[BAND_DTE_CH])
		else $error("Controller write of 1 not accepted");

	// Address and count registers take writes whatever the write enables say
	addr_write_a: assert property (apb_wr && paddr_i == OFF_MAR |=> mar_q == $past(pwdata_i[MAR_W-1:0]))
		else $error("Memory address write lost");
	io_side_address_write_a: assert property (apb_wr && paddr_i == OFF_IO_SIDE_ADDRESS
		|=> io_side_address_q == $past(pwdata_i[IO_SIDE_ADDRESS_W-1:0]))
		else $error("I/O address write lost");
	cnt_write_a: assert property (apb_wr && paddr_i == OFF_CNT
		|=> {hold_q, live_q} == $past(pwdata_i[2*CNT_W-1:0]))
		else $error("Count write lost");

	// Address generation
	src_dir_a: assert property (x.start |-> x.src == ($past(ctrl_q[CTRL_DIR]) ?
		{IO_SIDE_ADDRESS_PAGE, $past(io_side_address_q)} : $past(mar_q)))
		else $error("Source address does not follow direction");
	dst_dir_a: assert property (x.start |-> x.dst == ($past(ctrl_q[CTRL_DIR]) ?
		$past(mar_q) : {IO_SIDE_ADDRESS_PAGE, $past(io_side_address_q)}))
		else $error("Destination address does not follow direction");
	io_side_address_fixed_a: assert property (!(wr_en && wr_addr == OFF_IO_SIDE_ADDRESS) |=> $stable(io_side_address_q))
		else $error("I/O address moved without a write");

	// Repeat sequencing; a software clear of bit 4 mid-transfer is a legal halt
	mar_step_a: assert property (upd && !last && !(wr_en && wr_addr == OFF_MAR)
		|=> mar_q == mar_step($past(mar_q), $past(ctrl_q[CTRL_WORD]), $past(ctrl_q[CTRL_DEC])))
		else $error("Memory address did not step");
	reload_a: assert property (upd && last && repeat_mode && band_q[BAND_DTE_CH]
		&& !(wr_en && (wr_addr == OFF_MAR || wr_addr == OFF_CNT || wr_addr == OFF_BAND))
		|=> mar_q == mar_start_q && live_q == hold_q && band_q[BAND_DTE_CH])
		else $error("Repeat reload failed or channel stopped");
	repeat_keeps_a: assert property (upd && repeat_mode && band_q[BAND_DTE_CH]
		&& !(wr_en && wr_addr == OFF_BAND) |=> band_q[BAND_DTE_CH])
		else $error("Repeat mode channel stopped by itself");
	count_dec_a: assert property (upd && !last && !(wr_en && wr_addr == OFF_CNT)
		|=> live_q == $past(live_q) - CNT_LAST)
		else $error("Live count did not decrement");
	hold_fixed_a: assert property (!(wr_en && wr_addr == OFF_CNT) |=> $stable(hold_q))
		else $error("Hold count changed without a write");
	normal_end_a: assert property (hw_end && !(wr_en && wr_addr == OFF_BAND) |=> !band_q[BAND_DTE_CH])
		else $error("Normal mode did not stop at end of count");

	// Main scenarios
	repeat_wrap_c: cover property (upd && last && repeat_mode ##[1:40] x.start);
	normal_end_c: cover property (hw_end);
	dtc_write_c: cover property (dtc_wr && dtc_addr_i == OFF_BAND);
	io_to_mem_c: cover property (x.start && ctrl_q[CTRL_DIR]);
	stop_wait_c: cover property (stop_q && req_pend_q && band_q[BAND_DTE_CH]);
endmodule : dmarp_channel

// >>> bench/dmarp_bus_model.sv
// Memory and I/O slave on the channel's system bus
`timescale 1ns/1ps
module dmarp_bus_model (
	// Clock and reset
	input wire logic sys_clk_i,
	input wire logic rst_n_i,
	// Answer speed
	input wire logic slow_i,
	// Bus from the channel
	input wire logic bus_req_i,
	input wire logic [23:0] bus_addr_i,
	input wire logic bus_we_i,
	input wire logic [15:0] bus_wdata_i,
	output logic bus_ack_o,
	output logic [15:0] bus_rdata_o,
	// Log of the last write
	output logic [23:0] wr_addr_o,
	output logic [15:0] wr_data_o,
	output logic [7:0] wr_cnt_o
);
	logic [2:0] wait_q;
	logic gap_q;
	always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			bus_ack_o <= 1'b0;
			bus_rdata_o <= 16'h0000;
			wait_q <= 3'h0;
			gap_q <= 1'b0;
			wr_addr_o <= 24'h000000;
			wr_data_o <= 16'h0000;
			wr_cnt_o <= 8'h00;
		end else if (bus_ack_o) begin
			bus_ack_o <= 1'b0;
			gap_q <= 1'b1;
			// Data not held past the ack
			bus_rdata_o <= ~bus_rdata_o;
			if (bus_we_i) begin
				wr_addr_o <= bus_addr_i;
				wr_data_o <= bus_wdata_i;
				wr_cnt_o <= wr_cnt_o + 8'h01;
			end
		end else if (gap_q || !bus_req_i) begin
			// One idle edge so the next phase's address is seen
			gap_q <= 1'b0;
			wait_q <= 3'h0;
		end else if (wait_q >= (slow_i ? 3'h3 : 3'h0)) begin
			bus_ack_o <= 1'b1;
			bus_rdata_o <= {bus_addr_i[7:0], ~bus_addr_i[7:0]};
		end else begin
			wait_q <= wait_q + 3'h1;
		end
	end
endmodule : dmarp_bus_model

// >>> bench/tb.sv
// Self-checking bench for the repeat-mode channel
`timescale 1ns/1ps
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin n_fail++; $display("[ERR] %0t got %0h exp %0h", $time, (g), (e)); end end
module tb;
	import dmarp_pkg::*;
	logic clk, rst_n, psel, penable, pwrite, dtc_valid, xreq, slow;
	logic [APB_AW-1:0] paddr, dtc_addr;
	logic [APB_DW-1:0] pwdata, dtc_wdata, prdata, rdat;
	logic pready, pslverr, dtc_ready, breq, bwe, bword, back, rerr;
	logic [MAR_W-1:0] baddr, wr_addr;
	logic [DATA_W-1:0] bwdata, brdata, wr_data;
	logic [7:0] wr_cnt;
	int n_fail, tests_run;
	dmarp_channel dut (.sys_clk_i(clk), .rst_n_i(rst_n), .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite),
		.paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr),
		.dtc_valid_i(dtc_valid), .dtc_ready_o(dtc_ready), .dtc_addr_i(dtc_addr), .dtc_wdata_i(dtc_wdata),
		.xfer_req_i(xreq), .bus_req_o(breq), .bus_addr_o(baddr), .bus_we_o(bwe), .bus_word_o(bword),
		.bus_wdata_o(bwdata), .bus_ack_i(back), .bus_rdata_i(brdata));
	dmarp_bus_model mem (.sys_clk_i(clk), .rst_n_i(rst_n), .slow_i(slow), .bus_req_i(breq), .bus_addr_i(baddr),
		.bus_we_i(bwe), .bus_wdata_i(bwdata), .bus_ack_o(back), .bus_rdata_o(brdata), .wr_addr_o(wr_addr),
		.wr_data_o(wr_data), .wr_cnt_o(wr_cnt));
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	function automatic logic [15:0] pat(logic [23:0] a);
		return {a[7:0], ~a[7:0]};
	endfunction : pat
	task automatic summarize;
		$display("comparisons %0d mismatches %0d", tests_run, n_fail);
		if (n_fail == 0 && tests_run > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask : summarize
	task automatic fail_out(string m);
		n_fail++;
		$display("[ERR] %0t %s", $time, m);
		summarize();
	endtask : fail_out
	task automatic apb_go(logic w, logic [7:0] a, logic [31:0] d);
		int i;
		@(posedge clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		for (i = 0; i < 50; i++) begin
			@(posedge clk);
			if (pready === 1'b1) break;
		end
		if (i == 50) fail_out("apb timeout");
		rdat = prdata;
		rerr = pslverr;
		if (w) `CHK(dtc_ready, 1'b0);
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb_go
	task automatic wr(logic [7:0] a, logic [31:0] d);
		apb_go(1'b1, a, d);
	endtask : wr
	task automatic rd(logic [7:0] a, logic [31:0] e);
		apb_go(1'b0, a, 32'h0);
		`CHK({rerr, rdat}, {a > OFF_STAT, e});
	endtask : rd
	task automatic dtc_wr(logic [7:0] a, logic [31:0] d);
		int i;
		@(posedge clk);
		dtc_valid <= 1'b1;
		dtc_addr <= a;
		dtc_wdata <= d;
		for (i = 0; i < 50; i++) begin
			@(posedge clk);
			if (dtc_ready === 1'b1) break;
		end
		if (i == 50) fail_out("controller port timeout");
		dtc_valid <= 1'b0;
	endtask : dtc_wr
	// Pulse a request; go says whether a bus write must follow
	task automatic xfer(bit req, bit go);
		int i;
		logic [7:0] c0;
		c0 = wr_cnt;
		@(posedge clk);
		xreq <= req;
		@(posedge clk);
		xreq <= 1'b0;
		for (i = 0; i < 60; i++) begin
			@(posedge clk);
			if (wr_cnt !== c0) break;
		end
		if (go && i == 60) fail_out("no transfer");
		if (!go) `CHK(wr_cnt, c0);
		repeat (3) @(posedge clk);
	endtask : xfer
	task automatic rep(logic [4:0] c, logic [23:0] m, int st, logic [7:0] n, int reps);
		int k;
		logic [23:0] am;
		logic [15:0] pv;
		wr(OFF_BAND, 32'h0);
		wr(OFF_CTRL, {27'h0, c});
		wr(OFF_MAR, {8'h0, m});
		wr(OFF_CNT, {16'h0, n, n});
		wr(OFF_BAND, 32'h10);
		for (int i = 0; i < reps; i++) begin
			k = i % n;
			am = m + 24'(st * k);
			pv = pat(am);
			xfer(1'b1, 1'b1);
			`CHK(bword, c[CTRL_WORD]);
			if (c[CTRL_DIR]) begin
				`CHK(wr_addr, am);
				`CHK(wr_data, pat({IO_SIDE_ADDRESS_PAGE, 16'h1234}));
			end else begin
				`CHK(wr_addr, {IO_SIDE_ADDRESS_PAGE, 16'h1234});
				`CHK(wr_data[7:0], pv[7:0]);
			end
			rd(OFF_MAR, (k == n - 1) ? {8'h0, m} : {8'h0, am + 24'(st)});
			rd(OFF_CNT, {16'h0, n, (k == n - 1) ? n : 8'(n - 1 - k)});
		end
	endtask : rep
	initial begin
		{psel, penable, pwrite, dtc_valid, xreq, slow} = 6'h00;
		paddr = 8'h00;
		dtc_addr = 8'h00;
		pwdata = 32'h0;
		dtc_wdata = 32'h0;
		n_fail = 0;
		tests_run = 0;
		rst_n = 1'b0;
		repeat (4) @(posedge clk);
		rst_n <= 1'b1;
		rd(OFF_CTRL, 32'h0);
		rd(OFF_BAND, 32'h0);
		rd(OFF_WEN, 32'h0);
		rd(OFF_STAT, 32'h0);
		rd(8'h1C, 32'h0);
		$display("test reset done");
		wr(OFF_MAR, 32'hABCDEF);
		wr(OFF_IO_SIDE_ADDRESS, 32'h1234);
		wr(OFF_CNT, 32'h0303);
		rd(OFF_MAR, 32'hABCDEF);
		rd(OFF_IO_SIDE_ADDRESS, 32'h1234);
		rd(OFF_CNT, 32'h0303);
		wr(OFF_CTRL, 32'h1F);
		rd(OFF_CTRL, 32'h0);
		wr(OFF_BAND, 32'hFFFF);
		rd(OFF_BAND, 32'hFEEE);
		wr(OFF_WEN, 32'h3);
		wr(OFF_CTRL, 32'h1F);
		rd(OFF_CTRL, 32'h1F);
		wr(OFF_BAND, 32'hFFFF);
		rd(OFF_BAND, 32'hFFFF);
		wr(OFF_BAND, 32'hF000);
		dtc_wr(OFF_BAND, 32'h0010);
		rd(OFF_BAND, 32'hF010);
		dtc_wr(OFF_BAND, 32'h0000);
		rd(OFF_BAND, 32'hF000);
		$display("test protection done");
		rep(5'h04, 24'h001000, 1, 8'd3, 7);
		slow <= 1'b1;
		rep(5'h17, 24'h002000, -2, 8'd2, 5);
		$display("test repeat done");
		rep(5'h0C, 24'h003000, 1, 8'd1, 0);
		xfer(1'b1, 1'b1);
		rd(OFF_CNT, 32'h0100);
		rd(OFF_BAND, 32'h0);
		xfer(1'b1, 1'b0);
		wr(OFF_STAT, 32'h1);
		wr(OFF_BAND, 32'h10);
		xfer(1'b1, 1'b0);
		rd(OFF_STAT, 32'h1);
		wr(OFF_STAT, 32'h0);
		xfer(1'b0, 1'b1);
		$display("test stop done");
		summarize();
	end
endmodule : tb
